/* include/dfc_pkg.sv */
// Constants for the trace FIFO low byte port and comparator A extension slice
package dfc_pkg;
    // AHB-Lite bus widths
    localparam int HADDR_W = 8;
    localparam int HDATA_W = 32;
    localparam int IDX_W = 6;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FIFO_HIGH = 6'h06;
    localparam logic [IDX_W-1:0] IDX_FIFO_LOW = 6'h07;
    localparam logic [IDX_W-1:0] IDX_CMPA_EXT = 6'h08;
    localparam logic [IDX_W-1:0] IDX_FIFO_EXT = 6'h10;
    localparam logic [IDX_W-1:0] IDX_CMPA_ADDR = 6'h11;
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h12;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h13;
    // Comparator A extension fields
    localparam int EXT_RW_EN_BIT = 7;
    localparam int EXT_RW_VAL_BIT = 6;
    localparam int EXT_PAGE_SEL_BIT = 5;
    localparam int EXT_BIT16_BIT = 0;
    localparam logic [7:0] EXT_WR_MASK = 8'hE1;
    localparam logic [7:0] EXT_RESET = 8'h00;
    // Control register fields
    localparam int CTRL_DBG_EN_BIT = 0;
    localparam int CTRL_TRIG_START_BIT = 1;
    localparam int CTRL_EVENT_ONLY_BIT = 2;
    localparam logic [7:0] CTRL_WR_MASK = 8'h07;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CMPA_ADDR_RESET = 16'h0000;
    // Trace FIFO shape
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 24;
    // Status register fields
    localparam int STAT_EMPTY_BIT = 4;
    localparam int STAT_FULL_BIT = 5;
endpackage

/* rtl/dfc_cmp_a.sv */
// Comparator A address, direction and page qualification
`timescale 1ns/10ps
module dfc_cmp_a (
    input wire logic [7:0] extCfg,
    input wire logic [15:0] cmpAddr,
    input wire logic coreValid,
    input wire logic coreRead,
    input wire logic [15:0] coreAddr,
    input wire logic [16:0] coreLinearAddr,
    input wire logic linearSel,
    input wire logic pagedAccess,
    input wire logic [2:0] programPage,
    output logic [16:0] coreAddr17,
    output logic match
);
    import dfc_pkg::*;
    logic addrHit;
    logic rwHit;
    logic pageHit;
    // Paged program access versus plain or linear pointer address
    assign coreAddr17 = pagedAccess ? {programPage, coreAddr[13:0]} :
                        (linearSel ? coreLinearAddr : {1'b0, coreAddr});
    assign addrHit = coreAddr17 == {extCfg[EXT_BIT16_BIT], cmpAddr};
    assign rwHit = !extCfg[EXT_RW_EN_BIT] || (coreRead == extCfg[EXT_RW_VAL_BIT]);
    assign pageHit = pagedAccess == extCfg[EXT_PAGE_SEL_BIT];
    assign match = coreValid && addrHit && rwHit && pageHit;
endmodule

/* rtl/dfc_top.sv */
// Trace FIFO read port and comparator A extension behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module dfc_top #(
    parameter int DEPTH = dfc_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic endTraceCause,
    input wire logic hsel,
    input wire logic [dfc_pkg::HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [dfc_pkg::HDATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [dfc_pkg::HDATA_W-1:0] hrdata,
    output logic hresp,
    input wire logic coreValid,
    input wire logic coreRead,
    input wire logic [15:0] coreAddr,
    input wire logic [16:0] coreLinearAddr,
    input wire logic linearSel,
    input wire logic pagedAccess,
    input wire logic [2:0] programPage,
    input wire logic [7:0] coreData,
    output logic compareMatch
);
    import dfc_pkg::*;
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);

    logic [7:0] ext_reg;
    logic [7:0] ext_next;
    logic [15:0] cmpAddr_reg;
    logic [15:0] cmpAddr_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic wrPend_reg;
    logic [IDX_W-1:0] wrIdx_reg;
    logic hreadyout_reg;
    logic [HDATA_W-1:0] hrdata_reg;
    logic compareMatch_reg;
    logic [FIFO_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] rdPtr_reg;
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W:0] count_reg;

    // Bus decode
    wire addrPhase = hsel && htrans[1] && hready;
    wire rdAccept = addrPhase && !hwrite;
    wire [IDX_W-1:0] rdIdx = haddr[HADDR_W-1:2];
    wire wrExt = wrPend_reg && (wrIdx_reg == IDX_CMPA_EXT);
    wire wrAddr = wrPend_reg && (wrIdx_reg == IDX_CMPA_ADDR);
    wire wrCtrl = wrPend_reg && (wrIdx_reg == IDX_CTRL);

    // Write data lands at the end of the data phase
    assign ext_next = wrExt ? (hwdata[7:0] & EXT_WR_MASK) : ext_reg;
    assign cmpAddr_next = wrAddr ? hwdata[15:0] : cmpAddr_reg;
    assign ctrl_next = wrCtrl ? (hwdata[7:0] & CTRL_WR_MASK) : ctrl_reg;

    // End-trace reset keeps debug state while debug is enabled and trigger start is clear, so the trace survives the reset
    wire keepState = endTraceCause && ctrl_reg[CTRL_DBG_EN_BIT]
                     && !ctrl_reg[CTRL_TRIG_START_BIT];
    wire clearState = reset && !keepState;

    // Comparator A
    logic [16:0] coreAddr17;
    logic matchNow;
    dfc_cmp_a u_cmp (
        .extCfg(ext_reg),
        .cmpAddr(cmpAddr_reg),
        .coreValid(coreValid),
        .coreRead(coreRead),
        .coreAddr(coreAddr),
        .coreLinearAddr(coreLinearAddr),
        .linearSel(linearSel),
        .pagedAccess(pagedAccess),
        .programPage(programPage),
        .coreAddr17(coreAddr17),
        .match(matchNow)
    );

    // Trace FIFO
    wire eventOnly = ctrl_reg[CTRL_EVENT_ONLY_BIT];
    wire fifoEmpty = count_reg == '0;
    wire fifoFull = count_reg == DEPTH_CNT;
    wire [FIFO_W-1:0] headWord = fifoEmpty ? '0 : mem[rdPtr_reg];
    wire [FIFO_W-1:0] entry = eventOnly ? {16'h0000, coreData} : {7'h00, coreAddr17};
    // New captures are dropped while full so unread history is never overwritten
    wire push = matchNow && ctrl_reg[CTRL_DBG_EN_BIT] && !fifoFull;
    wire pop = rdAccept && (rdIdx == IDX_FIFO_LOW) && !fifoEmpty;

    // Read mux sees pending writes so read after write returns the new value
    logic [HDATA_W-1:0] rdData;
    always_comb begin
        case (rdIdx)
            IDX_FIFO_LOW: rdData = {24'h000000, headWord[7:0]};
            IDX_FIFO_HIGH: rdData = {24'h000000, headWord[15:8]};
            IDX_FIFO_EXT: rdData = {24'h000000, headWord[23:16]};
            IDX_CMPA_EXT: rdData = {24'h000000, ext_next};
            IDX_CMPA_ADDR: rdData = {16'h0000, cmpAddr_next};
            IDX_CTRL: rdData = {24'h000000, ctrl_next};
            IDX_STATUS: rdData = HDATA_W'({fifoFull, fifoEmpty, 4'(count_reg)});
            default: rdData = '0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrPend_reg <= 1'b0;
            wrIdx_reg <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= '0;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            wrIdx_reg <= rdIdx;
            hreadyout_reg <= 1'b1;
            if (rdAccept) begin
                hrdata_reg <= rdData;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (clearState) begin
            ext_reg <= EXT_RESET;
            cmpAddr_reg <= CMPA_ADDR_RESET;
            ctrl_reg <= CTRL_RESET;
            rdPtr_reg <= '0;
            wrPtr_reg <= '0;
            count_reg <= '0;
        end else if (reset) begin
            ext_reg <= ext_reg;
        end else begin
            ext_reg <= ext_next;
            cmpAddr_reg <= cmpAddr_next;
            ctrl_reg <= ctrl_next;
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (push && !reset) begin
            mem[wrPtr_reg] <= entry;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            compareMatch_reg <= 1'b0;
        end else begin
            compareMatch_reg <= matchNow;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;
    assign compareMatch = compareMatch_reg;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    wire addrHit = coreAddr17 == {ext_reg[EXT_BIT16_BIT], cmpAddr_reg};

    property p_low_byte;
        logic [7:0] b;
        (pop, b = headWord[7:0]) |=> hrdata[7:0] == b;
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

    property p_advance;
        pop && !reset |=> rdPtr_reg == PTR_W'($past(rdPtr_reg) + 1'b1);
    endproperty
    a_advance: assert property (p_advance) else $error("pointer not advanced");

    property p_rw_block;
        coreValid && ext_reg[EXT_RW_EN_BIT] && (coreRead != ext_reg[EXT_RW_VAL_BIT])
            |=> !compareMatch;
    endproperty
    a_rw_block: assert property (p_rw_block) else $error("direction ignored");

    property p_rw_ignored;
        coreValid && !ext_reg[EXT_RW_EN_BIT] && addrHit
            && (pagedAccess == ext_reg[EXT_PAGE_SEL_BIT]) |=> compareMatch;
    endproperty
    a_rw_ignored: assert property (p_rw_ignored) else $error("direction used");

    property p_page;
        pagedAccess != ext_reg[EXT_PAGE_SEL_BIT] |=> !compareMatch;
    endproperty
    a_page: assert property (p_page) else $error("page qualifier ignored");

    property p_paged_addr;
        pagedAccess |-> coreAddr17 == {programPage, coreAddr[13:0]};
    endproperty
    a_paged_addr: assert property (p_paged_addr) else $error("paged address wrong");

    property p_plain_addr;
        !pagedAccess && !linearSel |-> coreAddr17 == {1'b0, coreAddr};
    endproperty
    a_plain_addr: assert property (p_plain_addr) else $error("plain address wrong");

    property p_bit16;
        coreAddr17[16] != ext_reg[EXT_BIT16_BIT] |=> !compareMatch;
    endproperty
    a_bit16: assert property (p_bit16) else $error("bit 16 ignored");

    property p_keep;
        @(posedge core_clk) disable iff (1'b0)
        reset && keepState |=> ext_reg == $past(ext_reg) && ctrl_reg == $past(ctrl_reg);
    endproperty
    a_keep: assert property (p_keep) else $error("state lost on end-trace reset");

    property p_high_zero;
        push && eventOnly |-> entry[15:8] == 8'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high byte not zero");

    property p_match;
        matchNow |=> compareMatch ##1 (compareMatch == $past(matchNow));
    endproperty
    a_match: assert property (p_match) else $error("match not reported");

    property p_push_seen;
        push |=> !fifoEmpty;
    endproperty
    a_push_seen: assert property (p_push_seen) else $error("push lost");

    property p_c_pop;
        pop;
    endproperty
    c_pop: cover property (p_c_pop);

    property p_c_full;
        fifoFull;
    endproperty
    c_full: cover property (p_c_full);

    property p_c_match;
        compareMatch ##1 compareMatch;
    endproperty
    c_match: cover property (p_c_match);

    property p_c_keep;
        @(posedge core_clk) disable iff (1'b0) reset && keepState;
    endproperty
    c_keep: cover property (p_c_keep);
endmodule

/* tb/dfc_core_model.sv */
// Monitored core bus partner issuing single bus cycles
`timescale 1ns/10ps
module dfc_core_model (
    input wire logic core_clk,
    output logic coreValid,
    output logic coreRead,
    output logic [15:0] coreAddr,
    output logic [16:0] coreLinearAddr,
    output logic linearSel,
    output logic pagedAccess,
    output logic [2:0] programPage,
    output logic [7:0] coreData
);
    initial begin
        {coreValid, coreRead, coreAddr, coreLinearAddr} = '0;
        {linearSel, pagedAccess, programPage, coreData} = '0;
    end
    // One valid cycle, then release so a held cycle is never counted twice
    task automatic cycle(input logic rd, input logic [15:0] a, input logic [16:0] la,
        input logic ls, input logic pg, input logic [2:0] pp, input logic [7:0] d);
        @(posedge core_clk);
        coreValid <= 1'b1;
        coreRead <= rd;
        coreAddr <= a;
        coreLinearAddr <= la;
        linearSel <= ls;
        pagedAccess <= pg;
        programPage <= pp;
        coreData <= d;
        @(posedge core_clk);
        coreValid <= 1'b0;
        // Released lines show no stale address
        coreAddr <= ~a;
        coreLinearAddr <= ~la;
    endtask
endmodule

/* tb/dfc_top_tb.sv */
// Self-checking bench for the trace FIFO read port and comparator A extension
`timescale 1ns/10ps
module dfc_top_tb;
    logic core_clk, reset, endTraceCause, hsel, hwrite, hreadyout, hresp, compareMatch;
    logic coreValid, coreRead, linearSel, pagedAccess, pg, ls, rdb, m;
    logic [7:0] haddr, coreData, ext;
    logic [1:0] htrans;
    logic [2:0] hsize, programPage, pp;
    logic [31:0] hwdata, hrdata, seed, r, x, h, l, e;
    logic [15:0] coreAddr, a;
    logic [16:0] coreLinearAddr, la, addr17;
    logic [31:0] q[$];
    int errTotal = 0;
    int numChecks = 0;
    dfc_top #(.DEPTH(4)) dfc_top_i (.core_clk(core_clk), .reset(reset),
        .endTraceCause(endTraceCause), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .coreValid(coreValid),
        .coreRead(coreRead), .coreAddr(coreAddr), .coreLinearAddr(coreLinearAddr),
        .linearSel(linearSel), .pagedAccess(pagedAccess), .programPage(programPage),
        .coreData(coreData), .compareMatch(compareMatch));
    dfc_core_model dfc_core_model_i (.core_clk(core_clk), .coreValid(coreValid),
        .coreRead(coreRead), .coreAddr(coreAddr), .coreLinearAddr(coreLinearAddr),
        .linearSel(linearSel), .pagedAccess(pagedAccess), .programPage(programPage),
        .coreData(coreData));
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input string n, input logic [31:0] ex, input logic [31:0] got);
        numChecks++;
        if (got !== ex) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", n, ex, got);
        end
    endtask
    // Single AHB-Lite transfer; waits on hready, no assumed latency
    task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d,
        output logic [31:0] rv);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= ad;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, ad, d, dummy);
    endtask
    task automatic stopTest;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        errTotal++;
        stopTest;
    end
    initial begin
        {hsel, htrans, hwrite, haddr, hwdata, endTraceCause} = '0;
        hsize = 3'b010;
        reset = 1'b1;
        seed = 32'h76428C28;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        ahb(1'b0, 8'h20, 0, r); cmp("ext reset", 32'h0, r);
        wr(8'h20, 32'hFFFFFFFF);
        ahb(1'b0, 8'h20, 0, r); cmp("ext bits", 32'hE1, r);
        ahb(1'b0, 8'hFC, 0, r); cmp("unmapped", 32'h0, r);
        $display("test registers done");
        wr(8'h44, 32'h1234);
        wr(8'h48, 32'h1);
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            if (i % 6 == 0) begin
                ext = {seed[31:29], 4'h0, seed[28]};
                wr(8'h20, {24'h0, ext});
            end
            {pg, ls, rdb} = seed[2:0];
            // Biased toward hits so matches and a full FIFO both occur
            pp = seed[3] ? {ext[0], 2'b00} : seed[6:4];
            a = seed[9] ? 16'h1234 : seed[25:10];
            la = seed[7] ? {ext[0], 16'h1234} : seed[26:10];
            addr17 = pg ? {pp, a[13:0]} : (ls ? la : {1'b0, a});
            m = addr17 == {ext[0], 16'h1234} && (!ext[7] || ext[6] == rdb) && pg == ext[5];
            dfc_core_model_i.cycle(rdb, a, la, ls, pg, pp, seed[23:16]);
            // Match flop is launched at this edge; look once it has settled
            @(negedge core_clk);
            cmp("match", {31'h0, m}, {31'h0, compareMatch});
            if (m && q.size() < 4) q.push_back({15'h0, addr17});
        end
        $display("test comparator done");
        ahb(1'b0, 8'h4C, 0, r);
        cmp("status", {26'h0, q.size() == 4, q.size() == 0, 4'(q.size())}, r);
        repeat (5) begin
            ahb(1'b0, 8'h40, 0, x);
            ahb(1'b0, 8'h18, 0, h);
            ahb(1'b0, 8'h1C, 0, l);
            e = q.size() > 0 ? q.pop_front() : 32'h0;
            cmp("fifo word", e, {8'h0, x[7:0], h[7:0], l[7:0]});
        end
        ahb(1'b0, 8'h4C, 0, r); cmp("status empty", 32'h10, r);
        $display("test fifo done");
        wr(8'h48, 32'h5);
        wr(8'h20, 32'h0);
        repeat (2) begin
            seed = lfsr(seed);
            dfc_core_model_i.cycle(1'b0, 16'h1234, 17'h0, 1'b0, 1'b0, 3'h0, seed[7:0]);
            ahb(1'b0, 8'h18, 0, h); cmp("event high", 32'h0, h);
            ahb(1'b0, 8'h1C, 0, l); cmp("event low", {24'h0, seed[7:0]}, l);
        end
        $display("test event only done");
        for (int k = 0; k < 3; k++) begin
            wr(8'h20, 32'hE1);
            wr(8'h48, k == 1 ? 32'h3 : 32'h1);
            @(posedge core_clk);
            reset <= 1'b1;
            endTraceCause <= (k != 2);
            @(posedge core_clk);
            reset <= 1'b0;
            endTraceCause <= 1'b0;
            ahb(1'b0, 8'h20, 0, r); cmp("ext kept", k == 0 ? 32'hE1 : 32'h0, r);
        end
        $display("test end trace reset done");
        stopTest;
    end
endmodule
